/* src/uep_pkg.sv */
// uep_pkg: constants and carrier types for the endpoint fifo access port
// assumes an 8-bit firmware register port and a 25 MHz core clock
//
// Notes on behaviour
// - command/status bits: 7 empty, 6 ready, 5 setup, 4:3 pipe, 2 flush, 1 dir, 0 request
// - direction 1 is write, 0 is read; toggling it before release ends the transfer
// - flush empties the selected fifo even when it is not ready
// - pipe select 00 picks the control fifo, 01 the interrupt fifo
// - setup flag stays set until firmware clears it
// - ready shows whether the selected fifo can take the requested access
// - empty flag set on zero-length packet, cleared by fifo read or next setup
// - a packet holds at most eight bytes; ready drops at that limit
// - pipe busy with host is blocked; on finish pulse interrupt and show pipe
// - over three milliseconds idle sets suspend bit 0 and raises an interrupt
// - host resume sets resume bit 3 and interrupts the processor
// - end of resume clears suspend and raises another interrupt
// - remote wakeup bit 1 sends a wake pulse; host answers with resume
// - aux select 1 with bus select 0 turns d- into data, d+ into clock
// - aux mode: bits 4,5 read pins, bits 6,7 drive; output must be 1 to read
package uep_pkg;
   localparam logic [7:0] CMD_STATUS_ADDR = 8'h46;
   localparam logic [7:0] CTRL_FIFO_ADDR = 8'h48;
   localparam logic [7:0] INTR_FIFO_ADDR = 8'h49;
   localparam logic [7:0] BUS_STATUS_ADDR = 8'h1a;
   localparam logic [7:0] EP_SELECT_ADDR = 8'h1b;
   localparam int BIT_EMPTY = 7;
   localparam int BIT_READY = 6;
   localparam int BIT_SETUP = 5;
   localparam int BIT_PIPE_HI = 4;
   localparam int BIT_PIPE_LO = 3;
   localparam int BIT_FLUSH = 2;
   localparam int BIT_DIR = 1;
   localparam int BIT_REQ = 0;
   localparam int BIT_SUSPEND = 0;
   localparam int BIT_WAKE = 1;
   localparam int BIT_RESUME = 3;
   localparam int BIT_DATA_IN = 4;
   localparam int BIT_CLK_IN = 5;
   localparam int BIT_DATA_OUT = 6;
   localparam int BIT_CLK_OUT = 7;
   localparam int BIT_AUX_SEL = 4;
   localparam int BIT_BUS_SEL = 5;
   localparam logic [1:0] PIPE_CTRL = 2'h0;
   localparam logic [1:0] PIPE_INTR = 2'h1;
   localparam int FIFO_DEPTH = 8;
   localparam int CLK_HZ = 25000000;
   localparam int IDLE_US = 3000;
   localparam int IDLE_CYCLES = (CLK_HZ / 1000000) * IDLE_US + 1;
   localparam int WAKE_US = 10;
   localparam int WAKE_CYCLES = (CLK_HZ / 1000000) * WAKE_US;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] AUX_OUT_RESET = 2'h3;

   // register port access from firmware
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } uep_cpu_type;

   // events from the serial engine packet side
   typedef struct packed {
      logic push;
      logic [7:0] data;
      logic pipe;
      logic setup_token;
      logic packet_end;
      logic zero_len;
      logic pop;
      logic host_busy;
      logic activity;
      logic resume_sig;
   } uep_sie_type;
endpackage : uep_pkg

/* src/uep_port.sv */
// uep_port: fifo command/status, two endpoint fifos, suspend/resume, aux pin mode
// assumes firmware accesses are single-cycle strobes, engine events are pulses
`timescale 1ns/1ns
`default_nettype none
module uep_port #(
   parameter int DEPTH = uep_pkg::FIFO_DEPTH,
   parameter int IDLE_COUNT = uep_pkg::IDLE_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire uep_pkg::uep_cpu_type i_cpu,
   output logic [7:0] o_rdata,
   input wire uep_pkg::uep_sie_type i_sie,
   output logic [7:0] o_sie_data,
   output logic o_usb_int,
   output logic o_active_pipe_number,
   output logic o_wake_drive,
   output logic o_aux_mode,
   input wire logic i_dm,
   input wire logic i_dp,
   output logic o_dm,
   output logic o_dm_oe,
   output logic o_dp,
   output logic o_dp_oe
);
   localparam int CW = $clog2(DEPTH + 1);
   typedef enum logic [1:0] {ST_ACTIVE, ST_SUSPEND, ST_RESUME} uep_pwr_type;

   logic [7:0] mem [2][DEPTH];
   logic [CW-1:0] count [2];
   logic [CW-1:0] rptr [2];
   logic [7:0] cmd;
   logic setup_flag, empty_flag, next_setup_flag, next_empty_flag;
   logic setup_seen, next_setup_seen;
   logic wsel;
   logic [1:0] pipe_sel;
   logic sel, ready;
   logic [7:0] next_rdata;
   logic [7:0] bus_reg;
   logic [1:0] ep_sel;
   uep_pwr_type pwr, next_pwr;
   logic [31:0] idle_cnt, next_idle_cnt;
   logic [15:0] wake_cnt, next_wake_cnt;
   logic resume_flag, next_resume_flag;
   logic int_pulse, next_int_pulse;
   logic cpu_data_wr, cpu_data_rd;

   assign pipe_sel = {cmd[uep_pkg::BIT_PIPE_HI], cmd[uep_pkg::BIT_PIPE_LO]};
   assign sel = (pipe_sel == uep_pkg::PIPE_INTR);
   // flush acts on the pipe named in the same write, not the one held before
   assign wsel = ({i_cpu.wdata[uep_pkg::BIT_PIPE_HI], i_cpu.wdata[uep_pkg::BIT_PIPE_LO]} == uep_pkg::PIPE_INTR);
   // ready: requested, pipe not in host use, and room or data as direction asks
   always_comb begin
      ready = 1'b0;
      if (cmd[uep_pkg::BIT_REQ] && !(i_sie.host_busy && i_sie.pipe == sel)) begin
         if (cmd[uep_pkg::BIT_DIR])
            ready = count[sel] < CW'(DEPTH);
         else
            ready = rptr[sel] < count[sel];
      end
   end
   assign cpu_data_wr = i_cpu.wr && ready && cmd[uep_pkg::BIT_DIR]
      && (i_cpu.addr == (sel ? uep_pkg::INTR_FIFO_ADDR : uep_pkg::CTRL_FIFO_ADDR));
   assign cpu_data_rd = i_cpu.rd && ready && !cmd[uep_pkg::BIT_DIR]
      && (i_cpu.addr == (sel ? uep_pkg::INTR_FIFO_ADDR : uep_pkg::CTRL_FIFO_ADDR));

   // per-fifo storage and counts; flush clears regardless of ready
   for (genvar f = 0; f < 2; f++) begin : g_fifo
      logic [CW-1:0] next_count, next_rptr;
      logic flush, end_xfer;
      assign flush = i_cpu.wr && i_cpu.addr == uep_pkg::CMD_STATUS_ADDR
         && i_cpu.wdata[uep_pkg::BIT_FLUSH] && wsel == f[0];
      // direction toggled while request held closes the transfer
      assign end_xfer = i_cpu.wr && i_cpu.addr == uep_pkg::CMD_STATUS_ADDR && sel == f[0]
         && cmd[uep_pkg::BIT_REQ] && i_cpu.wdata[uep_pkg::BIT_DIR] != cmd[uep_pkg::BIT_DIR];
      always_comb begin
         next_count = count[f];
         next_rptr = rptr[f];
         if (flush) begin
            next_count = '0;
            next_rptr = '0;
         end else if (end_xfer && !cmd[uep_pkg::BIT_DIR]) begin
            next_count = '0; // packet consumed by firmware
            next_rptr = '0;
         end else begin
            if (cpu_data_wr && sel == f[0])
               next_count = count[f] + CW'(1);
            if (cpu_data_rd && sel == f[0])
               next_rptr = rptr[f] + CW'(1);
            if (i_sie.push && i_sie.pipe == f[0] && count[f] < CW'(DEPTH))
               next_count = count[f] + CW'(1);
            if (i_sie.pop && i_sie.pipe == f[0] && rptr[f] < count[f])
               next_rptr = rptr[f] + CW'(1);
            if (i_sie.packet_end && i_sie.pipe == f[0] && rptr[f] == count[f] && rptr[f] != '0) begin
               next_count = '0;
               next_rptr = '0;
            end
            if (i_sie.setup_token && f == 0) begin
               next_count = '0; // setup overwrites the control fifo
               next_rptr = '0;
            end
         end
      end
      always_ff @(posedge i_clk) begin
         if (i_reset) begin
            count[f] <= '0;
            rptr[f] <= '0;
         end else begin
            count[f] <= next_count;
            rptr[f] <= next_rptr;
         end
      end
   end

   // data array writes from either side
   always_ff @(posedge i_clk) begin
      if (cpu_data_wr)
         mem[sel][count[sel][CW-2:0]] <= i_cpu.wdata;
      else if (i_sie.push && count[i_sie.pipe] < CW'(DEPTH))
         mem[i_sie.pipe][count[i_sie.pipe][CW-2:0]] <= i_sie.data;
   end

   // setup and empty flags: hardware set beats firmware clear
   always_comb begin
      next_setup_flag = setup_flag;
      next_setup_seen = setup_seen;
      next_empty_flag = empty_flag;
      if (i_cpu.wr && i_cpu.addr == uep_pkg::CMD_STATUS_ADDR) begin
         next_setup_flag = setup_flag & i_cpu.wdata[uep_pkg::BIT_SETUP];
         next_empty_flag = empty_flag & i_cpu.wdata[uep_pkg::BIT_EMPTY];
      end
      if (i_cpu.rd && (i_cpu.addr == uep_pkg::CTRL_FIFO_ADDR || i_cpu.addr == uep_pkg::INTR_FIFO_ADDR))
         next_empty_flag = 1'b0;
      if (i_sie.setup_token)
         next_empty_flag = 1'b0;
      if (i_sie.packet_end && i_sie.zero_len)
         next_empty_flag = 1'b1;
      // token opens the packet, so the flag waits for its end with the data loaded
      if (i_sie.packet_end)
         next_setup_seen = 1'b0;
      if (i_sie.setup_token)
         next_setup_seen = 1'b1;
      if (i_sie.packet_end && i_sie.pipe == 1'b0 && setup_seen)
         next_setup_flag = 1'b1;
   end

   // firmware read mux, registered so the output comes from a flop
   always_comb begin
      next_rdata = uep_pkg::RESET_BYTE;
      case (i_cpu.addr)
         uep_pkg::CMD_STATUS_ADDR: begin
            next_rdata = cmd;
            next_rdata[uep_pkg::BIT_EMPTY] = empty_flag;
            next_rdata[uep_pkg::BIT_READY] = ready;
            next_rdata[uep_pkg::BIT_SETUP] = setup_flag;
         end
         uep_pkg::CTRL_FIFO_ADDR, uep_pkg::INTR_FIFO_ADDR:
            next_rdata = cpu_data_rd ? mem[sel][rptr[sel][CW-2:0]] : uep_pkg::RESET_BYTE;
         uep_pkg::BUS_STATUS_ADDR: begin
            next_rdata = '0;
            next_rdata[uep_pkg::BIT_SUSPEND] = (pwr != ST_ACTIVE);
            next_rdata[uep_pkg::BIT_RESUME] = resume_flag;
            next_rdata[uep_pkg::BIT_DATA_IN] = o_aux_mode & i_dm & bus_reg[uep_pkg::BIT_DATA_OUT];
            next_rdata[uep_pkg::BIT_CLK_IN] = o_aux_mode & i_dp & bus_reg[uep_pkg::BIT_CLK_OUT];
         end
         uep_pkg::EP_SELECT_ADDR: begin
            next_rdata = '0;
            next_rdata[uep_pkg::BIT_AUX_SEL] = ep_sel[0];
            next_rdata[uep_pkg::BIT_BUS_SEL] = ep_sel[1];
         end
         default: next_rdata = uep_pkg::RESET_BYTE;
      endcase
   end

   // command bits, pin mode and output registers
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cmd <= uep_pkg::RESET_BYTE;
         setup_flag <= 1'b0;
         empty_flag <= 1'b0;
         setup_seen <= 1'b0;
         bus_reg <= {uep_pkg::AUX_OUT_RESET, 6'h00};
         ep_sel <= 2'h0;
         o_rdata <= uep_pkg::RESET_BYTE;
         o_sie_data <= uep_pkg::RESET_BYTE;
      end else begin
         if (i_cpu.wr && i_cpu.addr == uep_pkg::CMD_STATUS_ADDR)
            cmd <= {3'h0, i_cpu.wdata[4:3], 1'b0, i_cpu.wdata[1:0]};
         if (i_cpu.wr && i_cpu.addr == uep_pkg::BUS_STATUS_ADDR)
            bus_reg <= i_cpu.wdata;
         if (i_cpu.wr && i_cpu.addr == uep_pkg::EP_SELECT_ADDR)
            ep_sel <= {i_cpu.wdata[uep_pkg::BIT_BUS_SEL], i_cpu.wdata[uep_pkg::BIT_AUX_SEL]};
         setup_flag <= next_setup_flag;
         empty_flag <= next_empty_flag;
         setup_seen <= next_setup_seen;
         o_rdata <= next_rdata;
         o_sie_data <= mem[i_sie.pipe][rptr[i_sie.pipe][CW-2:0]];
      end
   end

   // aux pin drive: open-drain style, low only when aux mode outputs a zero
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_aux_mode <= 1'b0;
         o_dm <= 1'b0;
         o_dp <= 1'b0;
         o_dm_oe <= 1'b0;
         o_dp_oe <= 1'b0;
      end else begin
         o_aux_mode <= ep_sel[0] & ~ep_sel[1];
         o_dm_oe <= ep_sel[0] & ~ep_sel[1] & ~bus_reg[uep_pkg::BIT_DATA_OUT];
         o_dp_oe <= ep_sel[0] & ~ep_sel[1] & ~bus_reg[uep_pkg::BIT_CLK_OUT];
      end
   end

   // suspend/resume power tracking; idle count is long so it is a parameter
   always_comb begin
      next_pwr = pwr;
      next_idle_cnt = idle_cnt;
      next_resume_flag = resume_flag;
      next_int_pulse = 1'b0;
      next_wake_cnt = (wake_cnt != '0) ? wake_cnt - 16'h0001 : '0;
      if (i_cpu.wr && i_cpu.addr == uep_pkg::BUS_STATUS_ADDR && i_cpu.wdata[uep_pkg::BIT_WAKE]
            && pwr == ST_SUSPEND)
         next_wake_cnt = 16'(uep_pkg::WAKE_CYCLES);
      if (i_sie.packet_end && !i_sie.host_busy)
         next_int_pulse = 1'b1;
      case (pwr)
         ST_ACTIVE: begin
            next_idle_cnt = i_sie.activity ? '0 : idle_cnt + 32'h0000_0001;
            next_resume_flag = 1'b0;
            if (idle_cnt >= 32'(IDLE_COUNT)) begin
               next_pwr = ST_SUSPEND;
               next_int_pulse = 1'b1;
            end
         end
         ST_SUSPEND: begin
            next_idle_cnt = '0;
            if (i_sie.resume_sig) begin
               next_pwr = ST_RESUME;
               next_resume_flag = 1'b1;
               next_int_pulse = 1'b1;
            end
         end
         ST_RESUME: begin
            if (!i_sie.resume_sig) begin
               next_pwr = ST_ACTIVE;
               next_resume_flag = 1'b0;
               next_int_pulse = 1'b1;
            end
         end
         default: next_pwr = ST_ACTIVE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         pwr <= ST_ACTIVE;
         idle_cnt <= '0;
         wake_cnt <= '0;
         resume_flag <= 1'b0;
         o_usb_int <= 1'b0;
         o_active_pipe_number <= 1'b0;
         o_wake_drive <= 1'b0;
      end else begin
         pwr <= next_pwr;
         idle_cnt <= next_idle_cnt;
         wake_cnt <= next_wake_cnt;
         resume_flag <= next_resume_flag;
         o_usb_int <= next_int_pulse;
         if (i_sie.packet_end)
            o_active_pipe_number <= i_sie.pipe;
         o_wake_drive <= (next_wake_cnt != '0);
      end
   end

   // checks
   ovf_guard_a: assert property (@(posedge i_clk) disable iff (i_reset)
      count[0] <= CW'(DEPTH) && count[1] <= CW'(DEPTH)) else $error("fifo count above limit");
   flush_empty_a: assert property (@(posedge i_clk) disable iff (i_reset)
      i_cpu.wr && i_cpu.addr == uep_pkg::CMD_STATUS_ADDR && i_cpu.wdata[uep_pkg::BIT_FLUSH]
      |=> count[$past(wsel)] == '0) else $error("flush did not empty fifo");
   suspend_int_a: assert property (@(posedge i_clk) disable iff (i_reset)
      pwr == ST_ACTIVE && next_pwr == ST_SUSPEND |=> o_usb_int) else $error("no interrupt on suspend");
   resume_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
      pwr == ST_SUSPEND && i_sie.resume_sig |=> resume_flag && o_usb_int) else $error("resume missed");
   resume_end_a: assert property (@(posedge i_clk) disable iff (i_reset)
      pwr == ST_RESUME && !i_sie.resume_sig |=> pwr == ST_ACTIVE && o_usb_int) else $error("resume end");
   setup_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
      setup_flag && !(i_cpu.wr && i_cpu.addr == uep_pkg::CMD_STATUS_ADDR) |=> setup_flag)
      else $error("setup flag lost");
   empty_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
      i_sie.packet_end && i_sie.zero_len |=> empty_flag) else $error("empty flag not set");
   aux_mode_a: assert property (@(posedge i_clk) disable iff (i_reset)
      ep_sel == 2'h1 |=> o_aux_mode) else $error("aux mode not entered");
   busy_block_a: assert property (@(posedge i_clk) disable iff (i_reset)
      i_sie.host_busy && i_sie.pipe == sel |-> !ready) else $error("ready during host use");
   cover_suspend_c: cover property (@(posedge i_clk) disable iff (i_reset) pwr == ST_SUSPEND);
   cover_full_c: cover property (@(posedge i_clk) disable iff (i_reset) count[1] == CW'(DEPTH));
   cover_resume_c: cover property (@(posedge i_clk) disable iff (i_reset) pwr == ST_RESUME);
   // setup capture and remote wake are the other paths worth seeing
   cover_setup_c: cover property (@(posedge i_clk) disable iff (i_reset) setup_flag);
   cover_wake_c: cover property (@(posedge i_clk) disable iff (i_reset) o_wake_drive && pwr == ST_SUSPEND);
endmodule : uep_port
`default_nettype wire

/* dv/uep_host_model.sv */
// uep_host_model: usb host side of the engine event interface
// assumes tb calls its tasks on the rising edge of i_clk
`timescale 1ns/1ns
`default_nettype none
module uep_host_model (
   input wire logic i_clk,
   input wire logic i_wake,
   input wire logic [7:0] i_sie_data,
   output uep_pkg::uep_sie_type o_sie
);
   logic wake_d = 1'b0;
   int resume_left = 0;
   initial begin
      o_sie = '0;
      o_sie.activity = 1'b1;
   end
   // host answers a wake pulse with resume, then bus traffic restarts
   always @(posedge i_clk) begin
      wake_d <= i_wake;
      if (wake_d && !i_wake) begin
         resume_left <= 100;
         o_sie.resume_sig <= 1'b1;
      end else if (resume_left == 1) begin
         o_sie.resume_sig <= 1'b0;
         o_sie.activity <= 1'b1;
      end
      if (resume_left > 0) resume_left <= resume_left - 1;
   end
   // one packet: optional setup token, bytes seed+i, end of packet
   task automatic send(input logic pipe, input int n, input logic setup, input logic zl, input logic [7:0] seed);
      @(posedge i_clk);
      o_sie.pipe <= pipe;
      o_sie.setup_token <= setup;
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk);
         o_sie.setup_token <= 1'b0;
         o_sie.push <= 1'b1;
         o_sie.data <= seed + 8'(i);
      end
      @(posedge i_clk);
      o_sie.setup_token <= 1'b0;
      o_sie.push <= 1'b0;
      o_sie.data <= ~o_sie.data; // released data does not keep its value
      o_sie.zero_len <= zl;
      o_sie.packet_end <= 1'b1;
      @(posedge i_clk);
      o_sie.packet_end <= 1'b0;
      o_sie.zero_len <= 1'b0;
   endtask : send
   // engine read of one byte: select pipe, let the byte settle, pop it
   task automatic pop(input logic pipe, output logic [7:0] b);
      @(posedge i_clk);
      o_sie.pipe <= pipe;
      repeat (2) @(posedge i_clk);
      b = i_sie_data;
      o_sie.pop <= 1'b1;
      @(posedge i_clk);
      o_sie.pop <= 1'b0;
   endtask : pop
   // host holds a pipe while it works on it
   task automatic busy(input logic b);
      @(posedge i_clk);
      o_sie.host_busy <= b;
   endtask : busy
   task automatic idle();
      @(posedge i_clk);
      o_sie.activity <= 1'b0;
   endtask : idle
endmodule : uep_host_model
`default_nettype wire

/* dv/tb.sv */
// tb: firmware-side scenarios against the endpoint fifo access port
// assumes idle count shortened to 50 cycles and pins pulled up when released
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   uep_pkg::uep_cpu_type cpu = '0;
   uep_pkg::uep_sie_type sie;
   logic [7:0] rdata;
   logic [7:0] sie_data;
   logic [7:0] d;
   logic usb_int, active_pipe_number, wake, aux_mode, dm, dm_oe, dp, dp_oe;
   logic dm_ext = 1'b1;
   logic dp_ext = 1'b1;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   int ints = 0;
   int i0;
   always #20 clk = ~clk;
   uep_port #(.IDLE_COUNT(50)) i_uep_port (.i_clk(clk), .i_reset(reset), .i_cpu(cpu), .o_rdata(rdata),
      .i_sie(sie), .o_sie_data(sie_data), .o_usb_int(usb_int), .o_active_pipe_number(active_pipe_number),
      .o_wake_drive(wake), .o_aux_mode(aux_mode), .i_dm(dm_oe ? dm : dm_ext), .i_dp(dp_oe ? dp : dp_ext),
      .o_dm(dm), .o_dm_oe(dm_oe), .o_dp(dp), .o_dp_oe(dp_oe));
   uep_host_model i_uep_host_model (.i_clk(clk), .i_wake(wake), .i_sie_data(sie_data), .o_sie(sie));
   // interrupt pulses are counted so each scenario can judge the delta
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (usb_int === 1'b1) ints <= ints + 1;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      cpu.wr <= 1'b1;
      cpu.addr <= a;
      cpu.wdata <= v;
      @(posedge clk);
      cpu.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      cpu.rd <= 1'b1;
      cpu.addr <= a;
      @(posedge clk);
      cpu.rd <= 1'b0;
      #1 v = rdata;
   endtask : rd
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
      logic [7:0] v;
      rd(a, v);
      chk(name, exp, v);
   endtask : rdchk
   // firmware spacing of two microseconds at 25 MHz
   task automatic gap();
      repeat (50) @(posedge clk);
   endtask : gap
   task automatic t_ctrl_read();
      i0 = ints;
      i_uep_host_model.send(1'b0, 3, 1'b1, 1'b0, 8'ha0);
      repeat (2) @(posedge clk); // interrupt is counted one edge after it rises
      chk("int_count", 8'h01, 8'(ints - i0));
      chk("active_pipe_number", 8'h00, {7'h00, active_pipe_number});
      wr(8'h46, 8'h20);
      wr(8'h46, 8'h21);
      gap();
      rdchk(8'h46, 8'h61, "status_ready");
      i_uep_host_model.busy(1'b1);
      rdchk(8'h46, 8'h21, "status_busy");
      i_uep_host_model.busy(1'b0);
      for (int i = 0; i < 3; i++) begin
         gap();
         rdchk(8'h48, 8'ha0 + 8'(i), "ctrl_byte");
      end
      gap();
      rdchk(8'h46, 8'h21, "status_drained");
      wr(8'h46, 8'h23);
      wr(8'h46, 8'h22);
      rdchk(8'h46, 8'h22, "setup_held");
      wr(8'h46, 8'h00);
      rdchk(8'h46, 8'h00, "setup_cleared");
      $display("test ctrl_read done");
   endtask : t_ctrl_read
   task automatic t_intr_write();
      wr(8'h46, 8'h0a);
      wr(8'h46, 8'h0b);
      gap();
      rdchk(8'h46, 8'h4b, "intr_ready");
      for (int i = 0; i < 8; i++) begin
         gap();
         wr(8'h49, 8'hc0 + 8'(i));
      end
      rdchk(8'h46, 8'h0b, "full_not_ready");
      wr(8'h46, 8'h09);
      wr(8'h46, 8'h08);
      for (int i = 0; i < 8; i++) begin
         i_uep_host_model.pop(1'b1, d);
         chk("intr_byte", 8'hc0 + 8'(i), d);
      end
      i0 = ints;
      i_uep_host_model.send(1'b1, 0, 1'b0, 1'b0, 8'h00);
      repeat (2) @(posedge clk);
      chk("int_count", 8'h01, 8'(ints - i0));
      chk("active_pipe_number", 8'h01, {7'h00, active_pipe_number});
      $display("test intr_write done");
   endtask : t_intr_write
   task automatic t_zero_flush();
      i_uep_host_model.send(1'b0, 0, 1'b0, 1'b1, 8'h00);
      rdchk(8'h46, 8'h88, "empty_set");
      i_uep_host_model.send(1'b0, 0, 1'b1, 1'b0, 8'h00);
      rdchk(8'h46, 8'h28, "empty_cleared");
      wr(8'h46, 8'h02);
      wr(8'h46, 8'h03);
      gap();
      rdchk(8'h46, 8'h43, "zlp_ready");
      wr(8'h46, 8'h01);
      wr(8'h46, 8'h00);
      i_uep_host_model.send(1'b1, 2, 1'b0, 1'b0, 8'h55);
      wr(8'h46, 8'h0d);
      wr(8'h46, 8'h09);
      gap();
      rdchk(8'h46, 8'h09, "flushed");
      wr(8'h46, 8'h08);
      $display("test zero_flush done");
   endtask : t_zero_flush
   task automatic t_suspend();
      int n;
      n = 0;
      i0 = ints;
      i_uep_host_model.idle();
      repeat (60) @(posedge clk);
      rd(8'h1a, d);
      chk("suspend_set", 8'h01, d & 8'h01);
      wr(8'h1a, 8'hc2);
      for (int i = 0; i < 300; i++) begin
         #1 if (wake === 1'b1) n++;
         @(posedge clk);
      end
      chk("wake_len", 8'd250, 8'(n));
      rd(8'h1a, d);
      chk("resume_seen", 8'h09, d & 8'h09);
      repeat (120) @(posedge clk);
      rd(8'h1a, d);
      chk("suspend_clear", 8'h00, d & 8'h01);
      chk("int_count", 8'h03, 8'(ints - i0));
      $display("test suspend done");
   endtask : t_suspend
   task automatic t_aux();
      wr(8'h1b, 8'h10);
      @(posedge clk); // pin mode flop follows the select one edge later
      #1 chk("aux_mode", 8'h01, {7'h00, aux_mode});
      dm_ext <= 1'b1;
      dp_ext <= 1'b0;
      wr(8'h1a, 8'hc0);
      rd(8'h1a, d);
      chk("pins_in", 8'h10, d & 8'h30);
      wr(8'h1a, 8'h80);
      @(posedge clk);
      #1 chk("dm_oe", 8'h01, {7'h00, dm_oe});
      chk("dp_oe", 8'h00, {7'h00, dp_oe});
      rd(8'h1a, d);
      chk("data_masked", 8'h00, d & 8'h10);
      wr(8'h1b, 8'h20);
      @(posedge clk);
      #1 chk("usb_mode", 8'h00, {7'h00, aux_mode});
      $display("test aux done");
   endtask : t_aux
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rdchk(8'h46, 8'h00, "status_reset");
      rdchk(8'h1b, 8'h00, "select_reset");
      t_ctrl_read();
      t_intr_write();
      t_zero_flush();
      t_suspend();
      t_aux();
      test_done();
   end
endmodule : tb
`default_nettype wire
